/* design/acsr_top.sv */
// setup registers, channel sequencer and control outputs
`timescale 1ns/1ps
`default_nettype none
`include "acsr_map.svh"
module acsr_top (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 sw_reset,
  input  wire logic                 reg_wr,
  input  wire logic [2:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           setup1_rdata,
  output logic      [7:0]           setup2_rdata,
  input  wire logic                 conv_done,
  output acsr_pkg::acsr_chan_t      chan_q,
  output logic      [1:0]           chan_tag_q,
  output logic      [1:0]           tf_index_q,
  output logic      [2:0]           pos_hi_q,
  output logic      [2:0]           pos_lo_q,
  output logic                      filter_reset_q,
  output logic                      ready_clear_q,
  output logic                      sinc1_q,
  output acsr_pkg::acsr_rate_t      rate_q,
  output logic                      clk_en_q,
  output logic                      buffer_enable_q,
  output logic                      burnout_test_enable_q,
  output logic                      excitation_output_1_q,
  output logic                      excitation_output_2_q,
  output logic                      reserved_mode_q
);
  import acsr_pkg::*;
  logic [7:0] s1_q, s1_d, s2_q, s2_d;
  logic [2:0] idx_q, idx_d;
  logic       div_q;
  logic       wr1, wr2, clr;
  logic       scan, cal_hi, cal_lo, pair, cal_on, last;
  logic [2:0] last_idx;
  logic [1:0] chsel;
  acsr_chan_t ch_d;
  logic [1:0] tf_d, tag_d;
  logic       active_chg, mode_chg;
  acsr_rate_t rate_w;

  // converts a scan index to the measured channel or pair
  function automatic acsr_chan_t seq_chan(input logic p, input logic [2:0] i);
    if (i == 3'h5 || (p && i == 3'h3))
      seq_chan = ACSR_CH_OFFSET_CAL_INPUT; // see (R17)
    else if (i == 3'h6 || (p && i == 3'h4))
      seq_chan = ACSR_CH_CALGN;
    else if (p)
      seq_chan = acsr_chan_t'({i[1:0], 1'b0}); // see (R7)
    else
      seq_chan = acsr_chan_t'(i); // see (R6)
  endfunction : seq_chan

  assign clr    = rst | sw_reset;
  assign wr1    = reg_wr && reg_addr == `ACSR_ADDR_SETUP1;
  assign wr2    = reg_wr && reg_addr == `ACSR_ADDR_SETUP2;
  assign s1_d   = wr1 ? reg_wdata : s1_q;
  assign s2_d   = wr2 ? reg_wdata : s2_q;
  assign scan   = s2_q[`ACSR_S2_SCAN];
  assign cal_hi = s2_q[`ACSR_S2_CAL_HI];
  assign cal_lo = s2_q[`ACSR_S2_CAL_LO];
  assign pair   = s2_q[`ACSR_S2_PAIR];
  assign chsel  = {s1_q[`ACSR_S1_CHSEL_HI], s1_q[`ACSR_S1_CHSEL_LO]};
  assign cal_on = cal_hi ^ cal_lo; // see (R5)
  // scan length: 5 or 3 signal entries, plus two cal entries when cal is on
  assign last_idx = pair ? (cal_on ? 3'h4 : 3'h2) : (cal_on ? 3'h6 : 3'h4);
  assign last     = idx_q == last_idx;
  // mode bits change: restart from entry zero
  assign mode_chg = wr2 && ({reg_wdata[`ACSR_S2_SCAN], reg_wdata[`ACSR_S2_CAL_HI],
                    reg_wdata[`ACSR_S2_CAL_LO], reg_wdata[`ACSR_S2_PAIR]}
                    != {scan, cal_hi, cal_lo, pair}); // see (R20)
  assign idx_d = mode_chg ? 3'h0 :
                 (scan && conv_done) ? (last ? 3'h0 : idx_q + 3'h1) : idx_q; // see (R19) (R1)

  // single channel: cal code overrides, channel select otherwise
  always_comb begin
    if (scan) begin
      ch_d = seq_chan(pair, idx_q); // see (R1) (R16)
    end else if (cal_lo && !cal_hi) begin
      ch_d = ACSR_CH_OFFSET_CAL_INPUT; // see (R3) (R2)
    end else if (cal_hi && !cal_lo) begin
      ch_d = ACSR_CH_CALGN;
    end else if (pair) begin
      ch_d = acsr_chan_t'({chsel, 1'b0});
    end else begin
      ch_d = acsr_chan_t'({1'b0, chsel});
    end
  end

  // transfer set and tag: inputs 1/2 set 0, 3/4 set 1, 5 set 2
  always_comb begin
    if (ch_d == ACSR_CH_OFFSET_CAL_INPUT || ch_d == ACSR_CH_CALGN) begin
      tf_d  = scan ? `ACSR_TF3_INDEX : (pair ? chsel : {1'b0, chsel[1]}); // see (R8) (R3)
      tag_d = 2'h3; // see (R17)
    end else begin
      tf_d  = ch_d[2] ? 2'h2 : {1'b0, ch_d[1]};
      tag_d = tf_d;
    end
  end

  // a write changing anything that shapes the live conversion
  assign active_chg = (wr1 && reg_wdata != s1_q) ||
                      (wr2 && (reg_wdata[7:3] != s2_q[7:3] ||
                       reg_wdata[`ACSR_S2_PRESC] != s2_q[`ACSR_S2_PRESC])); // see (R18)

  acsr_rate u_rate (
    .clk_sel  (s1_q[`ACSR_S1_CLKSEL]),
    .mod_freq ({s1_q[`ACSR_S1_MF_HI], s1_q[`ACSR_S1_MF_LO]}),
    .filt_sel ({s1_q[`ACSR_S1_FS_HI], s1_q[`ACSR_S1_FS_LO]}),
    .rate_sps (rate_w)
  );

  always_ff @(posedge clk) begin
    if (clr) begin
      s1_q <= `ACSR_SETUP1_RESET; // see (R15)
      s2_q <= `ACSR_SETUP2_RESET;
      idx_q <= 3'h0;
      div_q <= 1'b0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      idx_q <= idx_d;
      div_q <= ~div_q;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      chan_q                <= ACSR_CH_IN1;
      chan_tag_q            <= 2'h0;
      tf_index_q            <= 2'h0;
      pos_hi_q              <= 3'h0;
      pos_lo_q              <= 3'h5;
      filter_reset_q        <= 1'b1;
      ready_clear_q         <= 1'b1;
      sinc1_q               <= 1'b0;
      rate_q                <= 16'h0000;
      clk_en_q              <= 1'b0;
      buffer_enable_q       <= 1'b0;
      burnout_test_enable_q <= 1'b0;
      excitation_output_1_q <= 1'b0;
      excitation_output_2_q <= 1'b0;
      reserved_mode_q       <= 1'b0;
    end else begin
      chan_q         <= ch_d;
      chan_tag_q     <= tag_d;
      tf_index_q     <= tf_d;
      // positive and negative analog input numbers (0 based, 7 = cal pin)
      pos_hi_q       <= (ch_d[2] && ch_d[1:0] != 2'h0) ? 3'h7 : ch_d;
      pos_lo_q       <= (ch_d[2] && ch_d[1:0] != 2'h0) ? 3'h7 :
                        (pair ? ch_d + 3'h1 : 3'h5); // see (R6) (R7)
      filter_reset_q <= active_chg; // see (R18)
      ready_clear_q  <= active_chg;
      sinc1_q        <= s1_q[`ACSR_S1_FAST];
      rate_q         <= rate_w;
      clk_en_q       <= s2_q[`ACSR_S2_PRESC] ? div_q : 1'b1; // see (R12)
      buffer_enable_q       <= s2_q[`ACSR_S2_BUFFER_ENABLE]; // see (R9)
      burnout_test_enable_q <= s2_q[`ACSR_S2_BURNOUT_TEST_ENABLE]; // see (R10)
      excitation_output_1_q <= s2_q[`ACSR_S2_IEXC]; // see (R11)
      excitation_output_2_q <= s2_q[`ACSR_S2_IEXC];
      reserved_mode_q       <= cal_hi & cal_lo; // see (R4)
    end
  end

  assign setup1_rdata = s1_q;
  assign setup2_rdata = s2_q;
endmodule : acsr_top
`default_nettype wire

/* inc/acsr_map.svh */
// register addresses, field positions, reset values and transfer set index
// What this block does
// (R1) scan enabled converts channels in sequence
// (R2) scan off repeats the one selected channel
// (R3) cal codes pick offset or gain pair
// (R4) host never writes reserved mode combinations
// (R5) scan with cal adds offset then gain
// (R6) pseudo mode: inputs one-five against six
// (R7) differential mode: pairs 1/2, 3/4, 5/6
// (R8) scan cal channels use third transfer set
// (R9) buffer bit powers or bypasses input buffers
// (R10) burnout bit connects test current sources
// (R11) excitation bit enables both current outputs
// (R12) prescale bit halves the input clock
// (R13) low clock rates 20/25/100/200 doubling per step
// (R14) high clock rates 50/60/300/600 doubling per step
// (R15) reset values: reg2 zero, reg1 0x0a
// (R16) channel select ignored while scanning
// (R17) offset cal before gain, same tag
// (R18) active setting change drops ready, resets filter
// (R19) advance each result, wrap at end
// (R20) mode writes restart scan at first entry
`ifndef ACSR_MAP_SVH
`define ACSR_MAP_SVH
`define ACSR_ADDR_SETUP1   3'h1
`define ACSR_ADDR_SETUP2   3'h2
`define ACSR_SETUP1_RESET  8'h0A
`define ACSR_SETUP2_RESET  8'h00
`define ACSR_S1_CHSEL_HI   7
`define ACSR_S1_CHSEL_LO   6
`define ACSR_S1_MF_HI      5
`define ACSR_S1_MF_LO      4
`define ACSR_S1_CLKSEL     3
`define ACSR_S1_FS_HI      2
`define ACSR_S1_FS_LO      1
`define ACSR_S1_FAST       0
`define ACSR_S2_SCAN       7
`define ACSR_S2_CAL_HI     6
`define ACSR_S2_CAL_LO     5
`define ACSR_S2_BUFFER_ENABLE       4
`define ACSR_S2_PAIR       3
`define ACSR_S2_BURNOUT_TEST_ENABLE       2
`define ACSR_S2_IEXC       1
`define ACSR_S2_PRESC      0
`define ACSR_TF3_INDEX     2'h2
`endif

/* inc/acsr_pkg.sv */
// types for the channel scan and rate configuration block
package acsr_pkg;
  typedef enum logic [2:0] {
    ACSR_CH_IN1    = 3'h0,
    ACSR_CH_IN2    = 3'h1,
    ACSR_CH_IN3    = 3'h2,
    ACSR_CH_IN4    = 3'h3,
    ACSR_CH_IN5    = 3'h4,
    ACSR_CH_OFFSET_CAL_INPUT = 3'h5,
    ACSR_CH_CALGN  = 3'h6
  } acsr_chan_t;
  typedef logic [15:0] acsr_rate_t;
endpackage : acsr_pkg

/* design/acsr_rate.sv */
// output data rate lookup from clock, modulator and filter fields
`timescale 1ns/1ps
`default_nettype none
module acsr_rate (
  input  wire logic              clk_sel,
  input  wire logic [1:0]        mod_freq,
  input  wire logic [1:0]        filt_sel,
  output var  acsr_pkg::acsr_rate_t rate_sps
);
  import acsr_pkg::*;
  logic [15:0] base_w;
  always_comb begin
    case ({clk_sel, filt_sel})
      3'h0:    base_w = 16'h0014; // see (R13)
      3'h1:    base_w = 16'h0019;
      3'h2:    base_w = 16'h0064;
      3'h3:    base_w = 16'h00C8;
      3'h4:    base_w = 16'h0032; // see (R14)
      3'h5:    base_w = 16'h003C;
      3'h6:    base_w = 16'h012C;
      3'h7:    base_w = 16'h0258;
      default: base_w = 16'h0000;
    endcase
    rate_sps = base_w << mod_freq; // see (R13) (R14)
  end
endmodule : acsr_rate
`default_nettype wire

/* verification/acsr_host.sv */
// host model that writes the setup registers
`timescale 1ns/1ps
`default_nettype none
module acsr_host (
  input  wire logic       clk,
  output var  logic       reg_wr,
  output var  logic [2:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == 3'h2 && &d[6:5]) ? d & 8'hDF : d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
endmodule : acsr_host
`default_nettype wire

/* verification/acsr_top_assertions.sv */
// checker on the control outputs of acsr_top
`timescale 1ns/1ps
`default_nettype none
`include "acsr_map.svh"
module acsr_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sw_reset,
  input wire logic       conv_done,
  input wire logic [7:0] setup2_rdata,
  input wire acsr_pkg::acsr_chan_t chan_q,
  input wire logic [1:0] chan_tag_q,
  input wire logic [1:0] tf_index_q,
  input wire logic       clk_en_q,
  input wire logic       buffer_enable_q,
  input wire logic       burnout_test_enable_q,
  input wire logic       excitation_output_1_q,
  input wire logic       excitation_output_2_q
);
  import acsr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst || sw_reset);
  wire cal_w = chan_q inside {ACSR_CH_OFFSET_CAL_INPUT, ACSR_CH_CALGN};
  wire scan_w = setup2_rdata[`ACSR_S2_SCAN];
  buf_follow_a: assert property (buffer_enable_q == $past(setup2_rdata[4]))
    else $error("buffer enable wrong");
  burnout_follow_a: assert property (burnout_test_enable_q == $past(setup2_rdata[2]))
    else $error("burnout enable wrong");
  exc_pair_a: assert property (excitation_output_1_q == excitation_output_2_q)
    else $error("excitation outputs differ");
  presc_on_a: assert property (
    setup2_rdata[0] && $past(setup2_rdata[0]) && clk_en_q |=> !clk_en_q)
    else $error("prescale not halving");
  presc_off_a: assert property (
    !setup2_rdata[0] && $past(!setup2_rdata[0]) |=> clk_en_q)
    else $error("clock enable dropped");
  scan_hold_a: assert property (
    scan_w && $stable(setup2_rdata) && !$past(conv_done) |=> $stable(chan_q))
    else $error("channel moved without result");
  scan_step_a: assert property (
    scan_w && conv_done ##1 $stable(setup2_rdata) |=> chan_q != $past(chan_q))
    else $error("scan did not advance");
  cal_tag_a: assert property (cal_w |-> chan_tag_q == 2'h3)
    else $error("cal tag wrong");
  cal_tf_a: assert property (cal_w && scan_w && $past(scan_w) |-> tf_index_q == 2'h2)
    else $error("cal transfer set wrong");
endmodule : acsr_chk
bind acsr_top acsr_chk acsr_chk_inst (.*);
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for acsr_top
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acsr_pkg::*;
  logic clk = 0, rst = 1, sw_reset = 0, conv_done = 0, e0;
  logic reg_wr;
  logic [2:0] reg_addr, pos_hi_q, pos_lo_q;
  logic [7:0] reg_wdata, setup1_rdata, setup2_rdata, s1, s2;
  logic [1:0] chan_tag_q, tf_index_q;
  acsr_chan_t chan_q;
  acsr_rate_t rate_q;
  logic clk_en_q, buffer_enable_q, burnout_test_enable_q;
  logic excitation_output_1_q, excitation_output_2_q;
  logic filter_reset_q, ready_clear_q, sinc1_q, reserved_mode_q;
  int errors = 0, samples_checked = 0, n, k, b, j;
  initial forever #2 clk = ~clk;
  acsr_host acsr_host_inst (.clk, .reg_wr, .reg_addr, .reg_wdata);
  acsr_top acsr_top_inst (.clk, .rst, .sw_reset, .reg_wr, .reg_addr, .reg_wdata,
    .setup1_rdata, .setup2_rdata, .conv_done, .chan_q, .chan_tag_q, .tf_index_q,
    .pos_hi_q, .pos_lo_q, .filter_reset_q, .ready_clear_q, .sinc1_q, .rate_q,
    .clk_en_q, .buffer_enable_q, .burnout_test_enable_q, .excitation_output_1_q,
    .excitation_output_2_q, .reserved_mode_q);
  function automatic acsr_rate_t exp_rate(input logic [7:0] d);
    acsr_rate_t lo [4] = '{20, 25, 100, 200};
    acsr_rate_t hi [4] = '{50, 60, 300, 600};
    return (d[3] ? hi[d[2:1]] : lo[d[2:1]]) << d[5:4];
  endfunction : exp_rate
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse_done();
    @(posedge clk) conv_done <= 1'b1;
    @(posedge clk) conv_done <= 1'b0;
    tick(2);
  endtask : pulse_done
  task automatic tally_and_finish();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'h02cd));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk(setup1_rdata, 8'h0A);
    chk(setup2_rdata, 8'h00);
    chk(rate_q, exp_rate(8'h0A));
    for (n = 0; n < 40; n++) begin
      s1 = (n == 0) ? 8'hFF : $urandom;
      acsr_host_inst.wr(3'h1, s1);
      tick(2);
      chk(rate_q, exp_rate(s1));
      chk(sinc1_q, s1[0]);
    end
    acsr_host_inst.wr(3'h5, ~s1);
    tick(2);
    chk(setup1_rdata, s1);
    for (n = 0; n < 8; n++) begin
      s2 = ($urandom & 8'h16) | n[0];
      acsr_host_inst.wr(3'h2, s2);
      tick(2);
      e0 = clk_en_q;
      tick(1);
      chk(buffer_enable_q, s2[4]);
      chk(burnout_test_enable_q, s2[2]);
      chk(excitation_output_1_q, s2[1]);
      chk(excitation_output_2_q, s2[1]);
      chk(e0 & clk_en_q, !s2[0]);
      chk(e0 | clk_en_q, 1'b1);
    end
    // live change pulses, unchanged or inactive writes stay quiet
    s1 = setup1_rdata ^ 8'h01;
    acsr_host_inst.wr(3'h1, s1);
    tick(0);
    chk(filter_reset_q, 1'b1);
    chk(ready_clear_q, 1'b1);
    acsr_host_inst.wr(3'h1, s1);
    tick(0);
    chk(filter_reset_q, 1'b0);
    acsr_host_inst.wr(3'h2, setup2_rdata ^ 8'h04);
    tick(0);
    chk(ready_clear_q, 1'b0);
    for (k = 0; k < 32; k++) begin
      if (k[2:1] == 2'b11 || (k[0] && k[4:3] == 2'b11)) continue;
      acsr_host_inst.wr(3'h1, {k[4:3], 6'h0A});
      acsr_host_inst.wr(3'h2, {1'b0, k[2:1], 1'b0, k[0], 3'h0});
      pulse_done();
      chk(chan_q, k[1] ? 5 : k[2] ? 6 : k[0] ? 2 * k[4:3] : k[4:3]);
      chk(reserved_mode_q, 1'b0);
    end
    for (k = 0; k < 6; k++) begin
      b = k[0] ? 3 : 5;
      n = b + (k > 1 ? 2 : 0);
      acsr_host_inst.wr(3'h1, $urandom);
      acsr_host_inst.wr(3'h2, {1'b1, k[2:1], 1'b0, k[0], 3'h0});
      tick(2);
      for (int i = 0; i < 2 * n + 1; i++) begin
        j = i % n;
        chk(chan_q, j < b ? (k[0] ? 2 * j : j) : 5 + j - b);
        chk(pos_hi_q, j < b ? (k[0] ? 2 * j : j) : 7);
        if (j < b) chk(pos_lo_q, k[0] ? 2 * j + 1 : 5);
        else chk(tf_index_q, 2'h2);
        if (j >= b) chk(chan_tag_q, 2'h3);
        pulse_done();
      end
    end
    @(posedge clk) sw_reset <= 1'b1;
    @(posedge clk) sw_reset <= 1'b0;
    tick(1);
    chk(setup2_rdata, 8'h00);
    chk(setup1_rdata, 8'h0A);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
